// ---- design/ebp_bus_pins.sv ----
// Purpose: External bus sequencer and pin state control, plus port 0.
// Assumes: Core holds a request until reqDone; standby is entered between cycles.
// Notes: Every output comes from a flip-flop; halt mode needs no special handling.
`timescale 1ns/1ps
module ebp_bus_pins
  import ebp_pkg::*;
(
  // Clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Core side.
  input  wire ebp_pkg::ebp_req_type coreReq,
  output logic                     reqDone,
  output logic               [15:0] readData,
  output logic                     busHoldActive,
  // Mode controls.
  input  wire logic                busFunctionEnable,
  input  wire logic                separateMode,
  input  wire logic                standbyMode,
  // Bus pin inputs.
  input  wire logic          [15:0] adIn,
  input  wire logic                externalWaitN,
  input  wire logic                busHoldRequestN,
  // Bus pin outputs.
  output ebp_pkg::ebp_pins_type    busPins,
  // Port 0 configuration and pins.
  input  wire logic           [6:0] port0FunctionSelect,
  input  wire logic           [6:0] port0Direction,
  input  wire logic           [6:0] portOutData,
  input  wire logic           [1:0] timerHOut,
  input  wire logic           [6:0] port0PinIn,
  output logic               [6:0] port0PinOut,
  output logic               [6:0] port0PinOe,
  output logic               [6:0] portReadData,
  output logic                     nmiRequest,
  output logic               [3:0] externalIrqIn
);
  import ebp_pkg::*;

  // Whole state of the sequencer.
  typedef struct packed {
    ebp_state_type st;
    ebp_pins_type  pins;
    ebp_req_type   req;
    logic          done;
    logic [15:0]   rdata;
    logic          hold;   // Bus hold granted, kept as its own flop.
  } ebp_seq_type;

  ebp_seq_type state_ff;
  ebp_seq_type nxt_state;
  logic        clkLevel;
  logic        busTick;

  // Bus clock divider.
  ebp_clk_div #(
    .HALF(EBP_CLK_HALF)
  ) u_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clkLevel(clkLevel),
    .tick    (busTick)
  );

  // Port 0 direction and function control.
  ebp_port0 u_port0 (
    .sys_clk            (sys_clk),
    .rst                (rst),
    .port0FunctionSelect(port0FunctionSelect),
    .port0Direction     (port0Direction),
    .portOutData        (portOutData),
    .timerHOut          (timerHOut),
    .port0PinIn         (port0PinIn),
    .port0PinOut        (port0PinOut),
    .port0PinOe         (port0PinOe),
    .portReadData       (portReadData),
    .nmiRequest         (nmiRequest),
    .externalIrqIn      (externalIrqIn)
  );

  // Sequencer: states advance only on the bus tick, so pins other than the clock
  // output change once per bus clock period. Wait and hold are looked at only in the states that
  // may sample them.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    // The clock output runs while the bus is enabled and not in standby; in standby and port mode it is low.
    nxt_state.pins.busClockOutput = standbyMode ? 1'b0 : clkLevel;
    nxt_state.pins.clockOe = busFunctionEnable;
    if (!busFunctionEnable) begin
      // Port mode: every bus pin stays an input until the core enables the bus.
      nxt_state.pins = EBP_PINS_RESET;
      nxt_state.st = ST_IDLE;
    end else if (busTick) begin
      case (state_ff.st)
        ST_IDLE: begin
          if (standbyMode) begin
            // Standby: buses float, controls driven inactive high; wait and
            // hold request are not sampled here.
            nxt_state.pins.adOe = 1'b0;
            nxt_state.pins.addrOe = 1'b0;
            nxt_state.pins.chipSelectN = 4'hf;
            nxt_state.pins.chipSelectOe = 1'b1;
            nxt_state.pins.writeStrobeLowByteN = 1'b1;
            nxt_state.pins.writeStrobeHighByteN = 1'b1;
            nxt_state.pins.readStrobeN = 1'b1;
            nxt_state.pins.addressLatchStrobeN = 1'b1;
            nxt_state.pins.strobeOe = 1'b1;
            nxt_state.pins.busHoldAcknowledgeN = 1'b1;
            nxt_state.pins.holdAckOe = 1'b1;
          end else if (!busHoldRequestN) begin
            // Grant the bus: float everything the master will drive.
            nxt_state.st = ST_HOLD;
            nxt_state.pins.adOe = 1'b0;
            nxt_state.pins.addrOe = 1'b0;
            nxt_state.pins.chipSelectOe = 1'b0;
            nxt_state.pins.strobeOe = 1'b0;
            nxt_state.pins.busHoldAcknowledgeN = 1'b0;
            nxt_state.pins.holdAckOe = 1'b1;
          end else begin
            // Controls are driven whenever the bus is ours; chip selects keep the last access value.
            nxt_state.pins.strobeOe = 1'b1;
            nxt_state.pins.chipSelectOe = 1'b1;
            nxt_state.pins.holdAckOe = 1'b1;
            nxt_state.pins.busHoldAcknowledgeN = 1'b1;
            if (coreReq.valid) begin
              nxt_state.req = coreReq;
              case (coreReq.kind)
                KIND_INT_MEM: begin
                  // Address left as it was, data floats, strobes inactive.
                  nxt_state.pins.adOe = 1'b0;
                  nxt_state.done = 1'b1;
                end
                KIND_PERIPH: begin
                  // Peripheral address is shown but no strobe moves.
                  nxt_state.pins.addrOut = coreReq.addr;
                  nxt_state.pins.addrOe = 1'b1;
                  nxt_state.pins.adOe = 1'b0;
                  nxt_state.done = 1'b1;
                end
                KIND_EXTERNAL: begin
                  // T1: address out, chip select active; address strobe active only in multiplexed mode.
                  nxt_state.st = ST_T1;
                  nxt_state.pins.addrOut = coreReq.addr;
                  nxt_state.pins.addrOe = 1'b1;
                  nxt_state.pins.chipSelectN = ~(4'h1 << coreReq.chipIdx);
                  nxt_state.pins.addressLatchStrobeN = separateMode;
                  nxt_state.pins.adOut = coreReq.addr[15:0];
                  nxt_state.pins.adOe = ~separateMode;
                end
                default: begin
                  // Unknown kinds complete at once without touching the bus.
                  nxt_state.done = 1'b1;
                end
              endcase
            end
          end
        end
        ST_T1: begin
          // T2: strobes asserted; write data on the data lines.
          nxt_state.st = ST_T2;
          nxt_state.pins.addressLatchStrobeN = 1'b1;
          if (state_ff.req.write) begin
            nxt_state.pins.writeStrobeLowByteN = ~state_ff.req.byteEn[0];
            nxt_state.pins.writeStrobeHighByteN = ~state_ff.req.byteEn[1];
            nxt_state.pins.adOut = state_ff.req.wdata;
            nxt_state.pins.adOe = 1'b1;
          end else begin
            nxt_state.pins.readStrobeN = 1'b0;
            nxt_state.pins.adOe = 1'b0;
          end
        end
        ST_T2: begin
          // Wait is sampled only here; low stretches the access by a period.
          if (!externalWaitN) begin
            nxt_state.st = ST_T2;
          end else if (!separateMode) begin
            nxt_state.st = ST_T3;
          end else begin
            // Separate mode ends after T2; idle state follows.
            nxt_state.st = ST_TI;
            nxt_state.rdata = adIn;
            nxt_state.done = 1'b1;
            nxt_state.pins.writeStrobeLowByteN = 1'b1;
            nxt_state.pins.writeStrobeHighByteN = 1'b1;
            nxt_state.pins.readStrobeN = 1'b1;
          end
        end
        ST_T3: begin
          // Multiplexed mode ends after T3; idle state follows.
          nxt_state.st = ST_TI;
          nxt_state.rdata = adIn;
          nxt_state.done = 1'b1;
          nxt_state.pins.writeStrobeLowByteN = 1'b1;
          nxt_state.pins.writeStrobeHighByteN = 1'b1;
          nxt_state.pins.readStrobeN = 1'b1;
        end
        ST_TI: begin
          // Address, data and chip selects keep the last cycle values;
          // neither wait nor hold request is looked at here.
          nxt_state.st = ST_IDLE;
        end
        ST_HOLD: begin
          // Hold request keeps being sampled; wait is ignored.
          if (busHoldRequestN) begin
            nxt_state.st = ST_IDLE;
            nxt_state.pins.busHoldAcknowledgeN = 1'b1;
            nxt_state.pins.chipSelectN = 4'hf;
            nxt_state.pins.chipSelectOe = 1'b1;
            nxt_state.pins.writeStrobeLowByteN = 1'b1;
            nxt_state.pins.writeStrobeHighByteN = 1'b1;
            nxt_state.pins.readStrobeN = 1'b1;
            nxt_state.pins.addressLatchStrobeN = 1'b1;
            nxt_state.pins.strobeOe = 1'b1;
          end
        end
        default: begin
          nxt_state.st = ST_IDLE;
        end
      endcase
    end
    nxt_state.hold = (nxt_state.st == ST_HOLD);
  end

  // State register; reset floats every pin and selects port input mode.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff.st <= ST_IDLE;
      state_ff.pins <= EBP_PINS_RESET;
      state_ff.req <= '0;
      state_ff.done <= 1'b0;
      state_ff.rdata <= 16'h0000;
      state_ff.hold <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign busPins = state_ff.pins;
  assign reqDone = state_ff.done;
  assign readData = state_ff.rdata;
  assign busHoldActive = state_ff.hold;
endmodule

// ---- design/ebp_pkg.sv ----
// Purpose: Shared constants and types for the external bus pin state block.
// Assumes: One 200 MHz system clock, active-high asynchronous reset.
// Notes: Pin names are active low where they end in N.
// How it works
// - Internal memory access: data floats, strobes inactive.
// - Peripheral access: address out, data floats.
// - Reset floats pins; then port input mode.
// - Standby floats buses, clock low, strobes high.
// - Bus idle state holds values, strobes high.
// - Hold floats bus, acknowledge low, clock runs.
// - No wait or hold sampling when idle/standby.
// - Two byte write strobes plus wait input.
// - Address to bit 23, four chip selects.
// - Port 0 seven pins, per-bit direction.
// - Per-bit port or alternate function select.
// - Timer outputs drive; interrupt functions are inputs.
package ebp_pkg;

  // Bus geometry.
  localparam int EBP_DATA_W = 16;
  localparam int EBP_ADDR_W = 24;
  localparam int EBP_CS_N   = 4;
  localparam int EBP_P0_W   = 7;

  // Half period of the bus clock output in system clock cycles.
  localparam logic [3:0] EBP_CLK_HALF = 4'h1;

  // Port 0 pins whose alternate function is a timer output (bits 0 and 1).
  localparam logic [6:0] EBP_P0_ALT_OUT = 7'h03;
  // Port 0 pin positions of the interrupt inputs.
  localparam int EBP_P0_NMI_BIT = 2;
  localparam int EBP_P0_IRQ_LSB = 3;

  // Bus sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_T1   = 3'b001,
    ST_T2   = 3'b010,
    ST_T3   = 3'b011,
    ST_TI   = 3'b100,
    ST_HOLD = 3'b101
  } ebp_state_type;

  // Kind of core access.
  typedef enum logic [1:0] {
    KIND_INT_MEM  = 2'b00,
    KIND_PERIPH   = 2'b01,
    KIND_EXTERNAL = 2'b10
  } ebp_kind_type;

  // Core access request.
  typedef struct packed {
    logic         valid;
    ebp_kind_type kind;
    logic         write;
    logic [1:0]   byteEn;
    logic [1:0]   chipIdx;
    logic [23:0]  addr;
    logic [15:0]  wdata;
  } ebp_req_type;

  // Driven side of the bus pins.
  typedef struct packed {
    logic [15:0] adOut;
    logic        adOe;
    logic [23:0] addrOut;
    logic        addrOe;
    logic [3:0]  chipSelectN;
    logic        chipSelectOe;
    logic        writeStrobeLowByteN;
    logic        writeStrobeHighByteN;
    logic        readStrobeN;
    logic        addressLatchStrobeN;
    logic        strobeOe;
    logic        busHoldAcknowledgeN;
    logic        holdAckOe;
    logic        busClockOutput;
    logic        clockOe;
  } ebp_pins_type;

  // Every pin floats and reads as its inactive level during reset.
  localparam ebp_pins_type EBP_PINS_RESET = '{
    adOut: 16'h0000, adOe: 1'b0, addrOut: 24'h000000, addrOe: 1'b0,
    chipSelectN: 4'hf, chipSelectOe: 1'b0, writeStrobeLowByteN: 1'b1,
    writeStrobeHighByteN: 1'b1, readStrobeN: 1'b1, addressLatchStrobeN: 1'b1,
    strobeOe: 1'b0, busHoldAcknowledgeN: 1'b1, holdAckOe: 1'b0,
    busClockOutput: 1'b0, clockOe: 1'b0};

endpackage

// ---- design/ebp_clk_div.sv ----
// Purpose: Divides the system clock into the bus clock level and a bus tick.
// Assumes: halfPeriod of at least one, so a tick is at least two cycles apart.
// Notes: tick pulses for one cycle as the bus clock level falls.
`timescale 1ns/1ps
module ebp_clk_div
  import ebp_pkg::*;
#(
  parameter logic [3:0] HALF = ebp_pkg::EBP_CLK_HALF
) (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rst,
  // Divided outputs.
  output logic      clkLevel,
  output logic      tick
);
  import ebp_pkg::*;

  // Whole state of the divider.
  typedef struct packed {
    logic [3:0] count;
    logic       level;
    logic       tick;
  } ebp_div_type;

  ebp_div_type state_ff;
  ebp_div_type nxt_state;

  // Count half periods; a falling level starts the next bus clock period.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.tick = 1'b0;
    if (state_ff.count >= HALF - 4'h1) begin
      nxt_state.count = 4'h0;
      nxt_state.level = ~state_ff.level;
      nxt_state.tick = state_ff.level;
    end else begin
      nxt_state.count = state_ff.count + 4'h1;
    end
  end

  // State register.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign clkLevel = state_ff.level;
  assign tick = state_ff.tick;
endmodule

// ---- design/ebp_port0.sv ----
// Purpose: Port 0 pin control with per-bit direction and function select.
// Assumes: Alternate outputs come from the timer H block.
// Notes: Pins 0..1 carry timer outputs, 2 the NMI, 3..6 the IRQs.
`timescale 1ns/1ps
module ebp_port0
  import ebp_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Configuration: 1 selects alternate function; 1 in direction means input.
  input  wire logic [6:0] port0FunctionSelect,
  input  wire logic [6:0] port0Direction,
  input  wire logic [6:0] portOutData,
  input  wire logic [1:0] timerHOut,
  // Pins.
  input  wire logic [6:0] port0PinIn,
  output logic      [6:0] port0PinOut,
  output logic      [6:0] port0PinOe,
  // Readback and interrupt requests.
  output logic      [6:0] portReadData,
  output logic            nmiRequest,
  output logic      [3:0] externalIrqIn
);
  import ebp_pkg::*;

  // Whole state of the port.
  typedef struct packed {
    logic [6:0] pinOut;
    logic [6:0] pinOe;
    logic [6:0] readData;
    logic       nmi;
    logic [3:0] irq;
  } ebp_p0_type;

  ebp_p0_type state_ff;
  ebp_p0_type nxt_state;
  logic [6:0] bitOut;
  logic [6:0] bitOe;

  // Per-pin mux between port mode and alternate function.
  for (genvar i = 0; i < EBP_P0_W; i++) begin : g_pin
    if (EBP_P0_ALT_OUT[i]) begin : g_alt_out
      // Timer output pins drive in alternate mode.
      assign bitOut[i] = port0FunctionSelect[i] ? timerHOut[i] : portOutData[i];
      assign bitOe[i]  = port0FunctionSelect[i] | ~port0Direction[i];
    end else begin : g_alt_in
      // Interrupt pins are inputs in alternate mode.
      assign bitOut[i] = portOutData[i];
      assign bitOe[i]  = ~port0FunctionSelect[i] & ~port0Direction[i];
    end
  end

  // Register pin drive, readback and the gated interrupt inputs.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.pinOut = bitOut;
    nxt_state.pinOe = bitOe;
    nxt_state.readData = port0PinIn;
    nxt_state.nmi = port0FunctionSelect[EBP_P0_NMI_BIT] & port0PinIn[EBP_P0_NMI_BIT];
    nxt_state.irq = port0FunctionSelect[EBP_P0_IRQ_LSB +: 4] & port0PinIn[EBP_P0_IRQ_LSB +: 4];
  end

  // State register; all pins come up as inputs.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign port0PinOut = state_ff.pinOut;
  assign port0PinOe = state_ff.pinOe;
  assign portReadData = state_ff.readData;
  assign nmiRequest = state_ff.nmi;
  assign externalIrqIn = state_ff.irq;
endmodule

// ---- tb/ebp_bus_pins_assertions.sv ----
// Purpose: Port-level assertions for the bus pin state block.
// Assumes: One clock; standby and hold start from an idle bus.
// Notes: Port 0 outputs lag their controls by one cycle.
`timescale 1ns/1ps
module ebp_bus_pins_checker
  import ebp_pkg::*;
(
  // Clock and reset.
  input wire logic                  sys_clk,
  input wire logic                  rst,
  // Bus side.
  input wire logic                  reqDone,
  input wire logic                  busHoldActive,
  input wire logic                  busFunctionEnable,
  input wire logic                  standbyMode,
  input wire ebp_pkg::ebp_pins_type busPins,
  // Port 0.
  input wire logic [6:0]            port0FunctionSelect,
  input wire logic [6:0]            port0Direction,
  input wire logic [1:0]            timerHOut,
  input wire logic [6:0]            port0PinIn,
  input wire logic [6:0]            port0PinOut,
  input wire logic [6:0]            port0PinOe,
  input wire logic                  nmiRequest
);
  // One clock, one reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic strobesHigh;  // Every bus strobe reads inactive.
  logic busOe;        // Any bus group is driven.
  assign strobesHigh = busPins.writeStrobeLowByteN & busPins.writeStrobeHighByteN
                     & busPins.readStrobeN & busPins.addressLatchStrobeN;
  assign busOe = busPins.adOe | busPins.addrOe | busPins.chipSelectOe | busPins.strobeOe;

  bus_off_float_a: assert property (!busFunctionEnable [*2] |-> !busOe)
    else $error("bus driven while disabled");
  hold_float_a: assert property (
    busHoldActive [*2] |-> !busOe && !busPins.busHoldAcknowledgeN && busPins.holdAckOe)
    else $error("bus not released in hold");
  standby_park_a: assert property (
    (standbyMode && busFunctionEnable) [*8] |-> !busPins.adOe && !busPins.addrOe && strobesHigh
      && busPins.chipSelectN == 4'hf && busPins.busHoldAcknowledgeN && !busPins.busClockOutput)
    else $error("pins not parked in standby");
  // The bus clock toggles outside standby, hold included.
  clock_runs_a: assert property (
    (!standbyMode && busPins.clockOe) [*3] |-> busPins.busClockOutput != $past(busPins.busClockOutput))
    else $error("bus clock stopped");
  idle_held_a: assert property (
    reqDone && !$past(strobesHigh) |-> strobesHigh && $stable(busPins.addrOut) && $stable(busPins.chipSelectN))
    else $error("idle state lost address");
  port_oe_a: assert property (
    port0PinOe == ((~$past(port0Direction) & ~$past(port0FunctionSelect))
      | ($past(port0FunctionSelect) & EBP_P0_ALT_OUT)))
    else $error("port 0 direction wrong");
  timer_drive_a: assert property (
    ((port0PinOut ^ {5'h00, $past(timerHOut)}) & $past(port0FunctionSelect) & EBP_P0_ALT_OUT) == 7'h00)
    else $error("timer output not on pin");
  nmi_follow_a: assert property (nmiRequest == ($past(port0FunctionSelect[2]) & $past(port0PinIn[2])))
    else $error("nmi request wrong");

  cover property (busHoldActive [*4]);
  cover property (reqDone && !$past(strobesHigh));
  cover property ((standbyMode && busFunctionEnable) [*8]);
endmodule

bind ebp_bus_pins ebp_bus_pins_checker i_ebp_bus_pins_checker (.sys_clk, .rst, .reqDone, .busHoldActive,
  .busFunctionEnable, .standbyMode, .busPins, .port0FunctionSelect, .port0Direction, .timerHOut, .port0PinIn,
  .port0PinOut, .port0PinOe, .nmiRequest);

// ---- tb/ebp_ext_mem.sv ----
// Purpose: External memory and bus master beyond the pins.
// Assumes: Word memory decoding address bits 4 to 1 only.
// Notes: Undriven data and wait lines toggle, so stale samples fail.
`timescale 1ns/1ps
module ebp_ext_mem
  import ebp_pkg::*;
(
  // Clock and reset.
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Pins and test controls.
  input  wire ebp_pkg::ebp_pins_type busPins,
  input  wire logic [1:0]            waitTicks,
  input  wire logic                  holdWanted,
  // Lines driven from the board side.
  output logic      [15:0]           memData,
  output logic                       memOe,
  output logic                       externalWaitN,
  output logic                       busHoldRequestN
);
  logic [15:0] mem [16];  // Word store.
  logic [3:0]  cnt;       // Cycles the strobe has been low.
  logic        tgl;       // Pattern for undriven lines.
  logic        active;    // A read or write strobe is low.
  logic [3:0]  idx;       // Word index.
  assign active = busPins.strobeOe & ~(busPins.readStrobeN & busPins.writeStrobeLowByteN
                                      & busPins.writeStrobeHighByteN);
  assign idx = busPins.addrOut[4:1];
  assign memOe = active & ~busPins.readStrobeN;
  assign memData = memOe ? mem[idx] : {8{tgl, ~tgl}};
  // Wait stays low until the strobe is 2*waitTicks+1 cycles old.
  assign externalWaitN = active ? (cnt >= {1'b0, waitTicks, 1'b1}) : tgl;
  // The bus master asks for the bus while told to.
  assign busHoldRequestN = ~holdWanted;

  // Strobe timer; each byte lane stores under its own strobe.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      tgl <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 16'h0000;
      end
    end else begin
      tgl <= ~tgl;
      cnt <= !active ? 4'h0 : (cnt == 4'hf) ? cnt : cnt + 4'h1;
      if (busPins.strobeOe && !busPins.writeStrobeLowByteN) begin
        mem[idx][7:0] <= busPins.adOut[7:0];
      end
      if (busPins.strobeOe && !busPins.writeStrobeHighByteN) begin
        mem[idx][15:8] <= busPins.adOut[15:8];
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the external bus pin state block.
// Assumes: Inputs change on the falling clock edge.
// Notes: The driver queues read data owed; a monitor checks it on completion.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("BAD %0t check failed", $time); end end
module tb_top;
  import ebp_pkg::*;
  logic         sys_clk, rst, reqDone, busHoldActive, busFunctionEnable, separateMode, standbyMode;
  logic         externalWaitN, busHoldRequestN, memOe, holdWanted, nmiRequest, lastClk;
  ebp_req_type  coreReq;
  ebp_pins_type busPins;
  logic [15:0]  readData, adIn, memData, lastRd;
  logic [1:0]   waitTicks, timerHOut;
  logic [6:0]   port0FunctionSelect, port0Direction, portOutData, port0PinIn, port0PinOut;
  logic [6:0]   port0PinOe, portReadData, extDrv, oeE, outE, lvl;
  logic [3:0]   externalIrqIn;
  logic [12:0]  allOe;
  logic [15:0]  shadow [4];  // Expected memory words.
  logic [15:0]  expQ [$];    // Read data owed by pending accesses.
  int           fails, check_count, i;

  // Shared wires follow whichever side drives.
  assign adIn = busPins.adOe ? busPins.adOut : memData;
  assign port0PinIn = (port0PinOe & port0PinOut) | (~port0PinOe & extDrv);
  assign allOe = {busPins.adOe, busPins.addrOe, busPins.chipSelectOe, busPins.strobeOe,
                  busPins.holdAckOe, busPins.clockOe, port0PinOe};

  initial begin
    sys_clk = 1'b0;
    forever begin
      #2.5 sys_clk = ~sys_clk;
    end
  end

  ebp_bus_pins i_ebp_bus_pins (.sys_clk, .rst, .coreReq, .reqDone, .readData, .busHoldActive, .busFunctionEnable,
    .separateMode, .standbyMode, .adIn, .externalWaitN, .busHoldRequestN, .busPins, .port0FunctionSelect,
    .port0Direction, .portOutData, .timerHOut, .port0PinIn, .port0PinOut, .port0PinOe, .portReadData, .nmiRequest,
    .externalIrqIn);
  ebp_ext_mem i_ebp_ext_mem (.sys_clk, .rst, .busPins, .waitTicks, .holdWanted, .memData, .memOe, .externalWaitN,
    .busHoldRequestN);

  // Each completion takes the oldest owed read value.
  always @(negedge sys_clk) begin
    if (reqDone === 1'b1) begin
      if (expQ.size() == 0) begin
        fails++;
        $display("BAD %0t unexpected completion", $time);
      end else begin
        `CHK(readData, expQ.pop_front())
      end
    end
  end

  task automatic stop_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_hold(input logic v);
    int n;
    for (n = 0; n < 20 && busHoldActive !== v; n++) @(negedge sys_clk);
    if (busHoldActive !== v) begin
      fails++;
      stop_test();
    end
  endtask

  // One core access; notes strobes seen and the latch-to-done time.
  task automatic access(input ebp_kind_type k, input logic wr, input logic [1:0] be,
                        input logic [23:0] a, input logic [15:0] d, input logic [1:0] w);
    int n, t0;
    logic [2:0] seen;
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}};
    seen = 3'b000;
    t0 = -1;
    if (k == KIND_EXTERNAL) begin
      if (wr) shadow[a[2:1]] = (shadow[a[2:1]] & ~m) | (d & m);
      lastRd = wr ? d : shadow[a[2:1]];
    end
    expQ.push_back(lastRd);
    waitTicks = w;
    coreReq = '{valid: 1'b1, kind: k, write: wr, byteEn: be, chipIdx: a[23:22], addr: a, wdata: d};
    for (n = 0; n < 40 && reqDone !== 1'b1; n++) begin
      @(negedge sys_clk);
      seen |= ~{busPins.readStrobeN, busPins.writeStrobeHighByteN, busPins.writeStrobeLowByteN};
      if (busPins.addressLatchStrobeN === 1'b0 && t0 < 0) t0 = n;
    end
    if (reqDone !== 1'b1) begin
      fails++;
      stop_test();
    end
    coreReq.valid = 1'b0;
    `CHK(seen, (k == KIND_EXTERNAL) ? (wr ? {1'b0, be} : 3'b100) : 3'b000)
    if (k == KIND_INT_MEM) `CHK(busPins.adOe, 1'b0)
    if (k == KIND_PERIPH) `CHK({busPins.addrOut, busPins.addrOe, busPins.adOe}, {a, 2'b10})
    if (k == KIND_EXTERNAL) `CHK({busPins.addrOut, busPins.chipSelectN}, {a, ~(4'h1 << a[23:22])})
    if (k == KIND_EXTERNAL && !separateMode) `CHK(n - 1 - t0, 6 + 2 * w)
    repeat (4) @(negedge sys_clk);
  endtask

  initial begin
    rst = 1'b1;
    coreReq = '0;
    {busFunctionEnable, separateMode, standbyMode, holdWanted, waitTicks, timerHOut} = '0;
    {port0FunctionSelect, portOutData, extDrv, lastRd} = '0;
    port0Direction = 7'h7f;
    shadow = '{default: 16'h0000};
    void'($urandom(32'hb1e39378));
    repeat (10) @(negedge sys_clk);
    `CHK(allOe, 13'h0000)
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    repeat (5) @(negedge sys_clk);
    `CHK(allOe, 13'h0000)
    // Port 0: all-alternate, all-port, then random mixes.
    for (i = 0; i < 8; i++) begin
      port0FunctionSelect = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'($urandom);
      port0Direction = 7'($urandom);
      portOutData = 7'($urandom);
      timerHOut = 2'($urandom);
      extDrv = 7'($urandom);
      repeat (3) @(negedge sys_clk);
      oeE = (~port0Direction & ~port0FunctionSelect) | (port0FunctionSelect & EBP_P0_ALT_OUT);
      outE = (port0FunctionSelect & EBP_P0_ALT_OUT & {5'h00, timerHOut}) | (~port0FunctionSelect & portOutData);
      lvl = (oeE & outE) | (~oeE & extDrv);
      `CHK(port0PinOe, oeE)
      `CHK(port0PinOut & oeE, outE & oeE)
      `CHK({portReadData, nmiRequest, externalIrqIn}, {lvl, port0FunctionSelect[2] & lvl[2],
            port0FunctionSelect[6:3] & lvl[6:3]})
    end
    port0FunctionSelect = 7'h00;
    port0Direction = 7'h7f;
    busFunctionEnable = 1'b1;
    for (i = 0; i < 24; i++) begin
      separateMode = i[3];
      access(ebp_kind_type'(2'($urandom_range(2, 0))), 1'($urandom), 2'($urandom_range(3, 1)),
             24'($urandom) & 24'hffff07, 16'($urandom), 2'($urandom));
    end
    standbyMode = 1'b1;
    repeat (10) @(negedge sys_clk);
    `CHK({busPins.adOe, busPins.addrOe, busPins.chipSelectN, busPins.readStrobeN, busPins.writeStrobeLowByteN,
          busPins.writeStrobeHighByteN, busPins.addressLatchStrobeN, busPins.busHoldAcknowledgeN,
          busPins.busClockOutput}, 12'b001111111110)
    holdWanted = 1'b1;
    repeat (10) @(negedge sys_clk);
    `CHK({busHoldActive, busPins.busHoldAcknowledgeN}, 2'b01)
    standbyMode = 1'b0;
    wait_hold(1'b1);
    repeat (4) @(negedge sys_clk);
    `CHK({allOe[12:9], busPins.busHoldAcknowledgeN, busPins.holdAckOe}, 6'b000001)
    lastClk = busPins.busClockOutput;
    @(negedge sys_clk);
    `CHK(busPins.busClockOutput, ~lastClk)
    holdWanted = 1'b0;
    wait_hold(1'b0);
    repeat (2) @(negedge sys_clk);
    `CHK(busPins.busHoldAcknowledgeN, 1'b1)
    busFunctionEnable = 1'b0;
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK(allOe, 13'h0000)
    rst = 1'b0;
    repeat (5) @(negedge sys_clk);
    `CHK(allOe[12:7], 6'h00)
    stop_test();
  end
endmodule
